//--- core/i2cms_top.sv
// i2c master bus sequencer: start, repeated start, byte transmit, wishbone registers
`timescale 1ns/1ps
module i2cms_top (
    input  wire logic                   clk_i,
    input  wire logic                   rst_i,
    input  wire logic                   wb_cyc_i,
    input  wire logic                   wb_stb_i,
    input  wire logic                   wb_we_i,
    input  wire logic [7:0]             wb_adr_i,
    input  wire logic [3:0]             wb_sel_i,
    input  wire logic [31:0]            wb_dat_i,
    output logic      [31:0]            wb_dat_o,
    output logic                        wb_ack_o,
    input  wire logic                   sleep_i,
    input  wire logic                   scl_i,
    input  wire logic                   sda_i,
    output i2cms_pkg::i2cms_drive_s     drive_o
);
    import i2cms_pkg::*;

    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    i2cms_state_e st;
    logic       scl_m, scl_s, scl_q, sda_m, sda_s, sda_q;
    logic [7:0] tick_cnt;
    logic       tick;
    logic [6:0] reload;
    logic [6:0] cnt;
    logic       run;
    logic       load;
    logic       tmo;
    logic       start_request, restart_request, ack_received_flag;
    logic       buffer_full_flag, port_irq_flag, collision_irq_flag;
    logic       start_detected, write_collision_flag;
    logic [7:0] tx_rx_buffer, shift_register;
    logic [3:0] bitcnt;
    logic [7:0] win_cnt;
    logic       req, wr, rd_ctrl, wr_ctrl, wr_stat, wr_buf;
    logic       in_cond, in_tx, col;

    assign req     = wb_cyc_i && wb_stb_i && !wb_ack_o;
    // writes land at the edge where the master samples ack high
    assign wr      = wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i && wb_sel_i[0];
    assign rd_ctrl = (wb_adr_i == ADR_CTRL2);
    assign wr_ctrl = wr && rd_ctrl;
    assign wr_stat = wr && (wb_adr_i == ADR_STATUS);
    assign wr_buf  = wr && (wb_adr_i == ADR_BUFFER);
    assign in_cond = (st != S_IDLE) && !in_tx;
    assign in_tx   = (st == S_TX_LOW) || (st == S_TX_REL) || (st == S_TX_HIGH);
    assign tmo     = run && (cnt == 7'h00);

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            {scl_m, scl_s, scl_q} <= 3'b111;
            {sda_m, sda_s, sda_q} <= 3'b111;
        end else begin
            {scl_m, scl_s, scl_q} <= {scl_i, scl_m, scl_s};
            {sda_m, sda_s, sda_q} <= {sda_i, sda_m, sda_s};
        end
    end

    // ------------------------------------------------------------
    // half instruction cycle tick, gated in sleep
    // ------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tick_cnt <= 8'h00;
            tick     <= 1'b0;
        end else if (sleep_i) begin
            tick     <= 1'b0;
        end else if (tick_cnt == HALF_CYC - 8'h01) begin
            tick_cnt <= 8'h00;
            tick     <= 1'b1;
        end else begin
            tick_cnt <= tick_cnt + 8'h01;
            tick     <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // rate counter
    // ------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt <= 7'h00;
            run <= 1'b0;
        end else if (load) begin
            cnt <= reload;
            run <= 1'b1;
        end else if (tmo || st == S_IDLE) begin
            run <= 1'b0;
        end else if (run && tick && !sleep_i && cnt != 7'h00) begin
            cnt <= cnt - 7'h01;
        end
    end

    // ------------------------------------------------------------
    // sequencer
    // ------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st                <= S_IDLE;
            drive_o           <= '0;
            load              <= 1'b0;
            col               <= 1'b0;
            start_request     <= 1'b0;
            restart_request   <= 1'b0;
            buffer_full_flag  <= 1'b0;
            ack_received_flag <= 1'b0;
            shift_register    <= 8'h00;
            bitcnt            <= 4'h0;
        end else begin
            load <= 1'b0;
            col  <= 1'b0;
            case (st)
                S_IDLE: begin
                    if (wr_ctrl && wb_dat_i[C2_START]) begin
                        start_request <= 1'b1;
                        if (scl_s && sda_s) begin
                            load <= 1'b1;
                            st   <= S_ST_CHK;
                        end else begin
                            col           <= 1'b1;
                            start_request <= 1'b0;
                        end
                    end else if (wr_ctrl && wb_dat_i[C2_RESTRT]) begin
                        restart_request <= 1'b1;
                        drive_o.scl_oe  <= 1'b1;
                        st              <= S_RS_SCLL;
                    end else if (wr_buf) begin
                        buffer_full_flag <= 1'b1;
                        shift_register   <= wb_dat_i[7:0];
                        bitcnt           <= 4'h0;
                        drive_o.scl_oe   <= 1'b1;
                        drive_o.sda_oe   <= !wb_dat_i[7];
                        load             <= 1'b1;
                        st               <= S_TX_LOW;
                    end
                end
                S_ST_CHK: begin
                    if (!scl_s) begin
                        col           <= 1'b1;
                        start_request <= 1'b0;
                        drive_o       <= '0;
                        st            <= S_IDLE;
                    end else if (tmo && sda_s) begin
                        drive_o.sda_oe <= 1'b1;
                        load           <= 1'b1;
                        st             <= S_ST_HOLD;
                    end else if (tmo) begin
                        col           <= 1'b1;
                        start_request <= 1'b0;
                        st            <= S_IDLE;
                    end
                end
                S_ST_HOLD: begin
                    if (tmo) begin
                        start_request <= 1'b0;
                        st            <= S_IDLE;
                    end
                end
                S_RS_SCLL: begin
                    if (!scl_s) begin
                        drive_o.sda_oe <= 1'b0;
                        load           <= 1'b1;
                        st             <= S_RS_SDAR;
                    end
                end
                S_RS_SDAR: begin
                    if (tmo && sda_s) begin
                        drive_o.scl_oe <= 1'b0;
                        st             <= S_RS_SCLR;
                    end else if (tmo) begin
                        col             <= 1'b1;
                        restart_request <= 1'b0;
                        drive_o         <= '0;
                        st              <= S_IDLE;
                    end
                end
                S_RS_SCLR: begin
                    if (scl_s && !sda_s) begin
                        col             <= 1'b1;
                        restart_request <= 1'b0;
                        drive_o         <= '0;
                        st              <= S_IDLE;
                    end else if (scl_s) begin
                        load <= 1'b1;
                        st   <= S_RS_HIGH;
                    end
                end
                S_RS_HIGH: begin
                    if (!scl_s) begin
                        col             <= 1'b1;
                        restart_request <= 1'b0;
                        drive_o         <= '0;
                        st              <= S_IDLE;
                    end else if (tmo) begin
                        drive_o.sda_oe <= 1'b1;
                        load           <= 1'b1;
                        st             <= S_RS_SDAL;
                    end
                end
                S_RS_SDAL: begin
                    if (tmo) begin
                        restart_request <= 1'b0;
                        st              <= S_IDLE;
                    end
                end
                S_TX_LOW: begin
                    if (tmo) begin
                        drive_o.scl_oe <= 1'b0;
                        st             <= S_TX_REL;
                    end
                end
                S_TX_REL: begin
                    if (scl_s) begin
                        load <= 1'b1;
                        st   <= S_TX_HIGH;
                    end
                end
                S_TX_HIGH: begin
                    if (tmo) begin
                        drive_o.scl_oe <= 1'b1;
                        bitcnt         <= bitcnt + 4'h1;
                        if (bitcnt == BIT_ACK) begin
                            ack_received_flag <= sda_s;
                            drive_o.sda_oe    <= 1'b0;
                            st                <= S_IDLE;
                        end else if (bitcnt == BIT_LAST) begin
                            buffer_full_flag <= 1'b0;
                            drive_o.sda_oe   <= 1'b0;
                            load             <= 1'b1;
                            st               <= S_TX_LOW;
                        end else begin
                            shift_register <= {shift_register[6:0], 1'b0};
                            drive_o.sda_oe <= !shift_register[6];
                            load           <= 1'b1;
                            st             <= S_TX_LOW;
                        end
                    end
                end
                default: begin
                    st      <= S_IDLE;
                    drive_o <= '0;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // software registers and sticky flags
    // ------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            reload <= RELOAD_RST;
        end else if (wr && wb_adr_i == ADR_RELOAD) begin
            reload <= wb_dat_i[6:0];
        end
    end

    // port irq: start done, restart done, ninth clock; set beats clear
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            port_irq_flag <= 1'b0;
        end else if (tmo && (st == S_ST_HOLD || st == S_RS_SDAL)) begin
            port_irq_flag <= 1'b1;
        end else if (tmo && st == S_TX_HIGH && bitcnt == BIT_ACK) begin
            port_irq_flag <= 1'b1;
        end else if (wr_stat && wb_dat_i[ST_PIRQ]) begin
            port_irq_flag <= 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            collision_irq_flag <= 1'b0;
        end else if (col) begin
            collision_irq_flag <= 1'b1;
        end else if (wr_stat && wb_dat_i[ST_CIRQ]) begin
            collision_irq_flag <= 1'b0;
        end
    end

    // start seen on the bus; cleared by a stop seen on the bus
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            start_detected <= 1'b0;
        end else if (scl_s && sda_q && !sda_s) begin
            start_detected <= 1'b1;
        end else if (scl_s && !sda_q && sda_s) begin
            start_detected <= 1'b0;
        end
    end

    // buffer writes outside idle: write collision and the rewrite window
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            write_collision_flag <= 1'b0;
            tx_rx_buffer         <= 8'h00;
            win_cnt              <= 8'h00;
        end else begin
            if (win_cnt != 8'h00) begin
                win_cnt <= win_cnt - 8'h01;
            end
            if (wr_buf && in_cond) begin
                write_collision_flag <= 1'b1;
            end else if (wr_buf && in_tx) begin
                write_collision_flag <= 1'b1;
                if (win_cnt != 8'h00) begin
                    tx_rx_buffer <= wb_dat_i[7:0];
                end else begin
                    win_cnt <= WRITE_COLLISION_FLAG_WIN;
                end
            end else if (wr_stat && wb_dat_i[ST_WRITE_COLLISION_FLAG]) begin
                write_collision_flag <= 1'b0;
            end
            if (wr_buf && st == S_IDLE) begin
                tx_rx_buffer <= wb_dat_i[7:0];
            end
        end
    end

    // ------------------------------------------------------------
    // wishbone slave: one wait state, unmapped reads zero
    // ------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= req;
            wb_dat_o <= 32'h0000_0000;
            if (req) begin
                case (wb_adr_i)
                    ADR_CTRL2: begin
                        wb_dat_o[C2_START]  <= start_request;
                        wb_dat_o[C2_RESTRT] <= restart_request;
                        wb_dat_o[C2_ACKRCV] <= ack_received_flag;
                    end
                    ADR_STATUS: begin
                        wb_dat_o[ST_BF]   <= buffer_full_flag;
                        wb_dat_o[ST_PIRQ] <= port_irq_flag;
                        wb_dat_o[ST_CIRQ] <= collision_irq_flag;
                        wb_dat_o[ST_SDET] <= start_detected;
                        wb_dat_o[ST_WRITE_COLLISION_FLAG] <= write_collision_flag;
                    end
                    ADR_RELOAD: wb_dat_o[6:0] <= reload;
                    ADR_BUFFER: wb_dat_o[7:0] <= tx_rx_buffer;
                    default:    wb_dat_o      <= 32'h0000_0000;
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    a_cnt_step: assert property (run && tick && !sleep_i && !load && !tmo && cnt != 7'h00
        |=> cnt == $past(cnt) - 7'h01) else $error("rate counter did not step");
    a_arb_reload: assert property (st == S_TX_REL && scl_s |=> load ##1 cnt == reload && st == S_TX_HIGH)
        else $error("no reload after scl high");
    a_sleep_freeze: assert property (sleep_i && !load && !$past(load) |=> $stable(cnt))
        else $error("counter moved in sleep");
    a_start_drive: assert property (st == S_ST_CHK && tmo && scl_s && sda_s
        |=> drive_o.sda_oe && !drive_o.scl_oe && st == S_ST_HOLD) else $error("start edge missing");
    a_start_done: assert property (st == S_ST_HOLD && tmo
        |=> !start_request && st == S_IDLE && port_irq_flag && drive_o.sda_oe) else $error("start not done");
    a_start_col: assert property (st == S_ST_CHK && !scl_s |=> st == S_IDLE ##1 collision_irq_flag)
        else $error("start collision missed");
    a_write_collision_flag_cond: assert property (wr_buf && in_cond |=> write_collision_flag && $stable(tx_rx_buffer))
        else $error("buffer changed during condition");
    a_lock_ctrl: assert property (wr_ctrl && wb_dat_i[C2_RESTRT] && st != S_IDLE && !restart_request
        |=> !restart_request) else $error("control write not locked");
    a_rs_col: assert property (st == S_RS_SCLR && scl_s && !sda_s |=> st == S_IDLE && !restart_request)
        else $error("restart collision missed");
    a_bf_clear: assert property (st == S_TX_HIGH && tmo && bitcnt == BIT_LAST
        |=> !buffer_full_flag && !drive_o.sda_oe && drive_o.scl_oe) else $error("eighth edge wrong");
    a_ack_record: assert property (st == S_TX_HIGH && tmo && bitcnt == BIT_ACK
        |=> ack_received_flag == $past(sda_s) && st == S_IDLE && drive_o.scl_oe)
        else $error("ack not recorded");
    a_write_collision_flag_sticky: assert property (write_collision_flag && !(wr_stat && wb_dat_i[ST_WRITE_COLLISION_FLAG])
        |=> write_collision_flag) else $error("write collision lost");

    c_start: cover property (st == S_ST_HOLD && tmo);
    c_restart: cover property (st == S_RS_SDAL && tmo);
    c_byte: cover property (st == S_TX_HIGH && tmo && bitcnt == BIT_ACK);
    c_collide: cover property (col);
endmodule // i2cms_top

//--- core/i2cms_pkg.sv
// constants, types and register map of the i2c master bus sequencer
package i2cms_pkg;
    // ------------------------------------------------------------
    // register map (byte addresses, one word each)
    // ------------------------------------------------------------
    localparam logic [7:0] ADR_CTRL2  = 8'h00;
    localparam logic [7:0] ADR_STATUS = 8'h04;
    localparam logic [7:0] ADR_RELOAD = 8'h08;
    localparam logic [7:0] ADR_BUFFER = 8'h0C;
    // control_two_register fields
    localparam int C2_START  = 0;
    localparam int C2_RESTRT = 1;
    localparam int C2_ACKRCV = 6;
    // port_status_register fields
    localparam int ST_BF     = 0;
    localparam int ST_PIRQ   = 1;
    localparam int ST_CIRQ   = 2;
    localparam int ST_SDET   = 3;
    localparam int ST_WRITE_COLLISION_FLAG   = 7;
    localparam logic [6:0] RELOAD_RST = 7'h09;
    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_NS        = 5;
    localparam int INSTR_CYC_NS  = 100;
    localparam int TICKS_PER_CYC = 2;
    localparam logic [7:0] HALF_CYC = 8'(INSTR_CYC_NS / TICKS_PER_CYC / CLK_NS);
    localparam int WRITE_COLLISION_FLAG_WIN_TCY  = 2;
    localparam logic [7:0] WRITE_COLLISION_FLAG_WIN = 8'(WRITE_COLLISION_FLAG_WIN_TCY * INSTR_CYC_NS / CLK_NS);
    localparam logic [3:0] BIT_LAST = 4'h7;
    localparam logic [3:0] BIT_ACK  = 4'h8;
    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        S_IDLE    = 4'b0000,
        S_ST_CHK  = 4'b0001,
        S_ST_HOLD = 4'b0010,
        S_RS_SCLL = 4'b0011,
        S_RS_SDAR = 4'b0100,
        S_RS_SCLR = 4'b0101,
        S_RS_HIGH = 4'b0110,
        S_RS_SDAL = 4'b0111,
        S_TX_LOW  = 4'b1000,
        S_TX_REL  = 4'b1001,
        S_TX_HIGH = 4'b1010
    } i2cms_state_e;
    typedef struct packed {
        logic scl_out;
        logic scl_oe;
        logic sda_out;
        logic sda_oe;
    } i2cms_drive_s;
endpackage

//--- tb/i2cms_slave.sv
// acknowledging i2c slave with optional clock stretching, pull-up lines
`timescale 1ns/1ps
module i2cms_slave (
    input  wire logic clk_i,
    input  wire logic rst_i,
    input  wire logic ack_en_i,
    input  wire logic stretch_i,
    input  wire logic scl_oe_i,
    input  wire logic sda_oe_i,
    output logic      scl_o,
    output logic      sda_o
);
    logic [3:0] falls;
    logic [6:0] hold;
    logic       scl_q;
    logic       sda_q;
    // wired-and with pull-up: any enable pulls the line low
    assign scl_o = ~(scl_oe_i | (hold != 7'h00));
    assign sda_o = ~(sda_oe_i | (ack_en_i & (falls == 4'h9)));
    always_ff @(posedge clk_i) begin
        scl_q <= scl_o;
        sda_q <= sda_o;
        if (rst_i) begin
            falls <= 4'h0;
            hold  <= 7'h00;
        end else if (sda_q & ~sda_o & scl_o) begin
            falls <= 4'h0;
        end else if (scl_q & ~scl_o) begin
            falls <= falls + 4'h1;
            hold  <= stretch_i ? 7'h3C : 7'h00;
        end else if (hold != 7'h00) begin
            hold <= hold - 7'h01;
        end
    end
endmodule // i2cms_slave

//--- tb/i2cms_top_tb.sv
// self-checking bench for the i2c master bus sequencer
`timescale 1ns/1ps
module i2cms_top_tb;
    import i2cms_pkg::*;
    logic         clk_i, rst_i, cyc, stb, we, ack, scl, sda, ack_en, stretch, slp;
    logic         scl_q = 1'b1, sda_q = 1'b1, scl_at_fall = 1'b0;
    logic [7:0]   adr;
    logic [8:0]   rx = 9'h000;
    logic [31:0]  dat, rd, dat_o;
    int           num_errors = 0, comparisons = 0, cyc_cnt = 0, hi_cnt = 0;
    i2cms_drive_s drv;
    i2cms_top dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(4'h1), .wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack), .sleep_i(slp), .scl_i(scl),
        .sda_i(sda), .drive_o(drv));
    i2cms_slave far (.clk_i(clk_i), .rst_i(rst_i), .ack_en_i(ack_en), .stretch_i(stretch),
        .scl_oe_i(drv.scl_oe), .sda_oe_i(drv.sda_oe), .scl_o(scl), .sda_o(sda));
    initial begin
        clk_i = 1'b0;
        forever #2.5 clk_i = ~clk_i;
    end
    // ------------------------------------------------------------
    // bus monitor and timeout
    // ------------------------------------------------------------
    always @(posedge clk_i) begin
        scl_q <= scl;
        sda_q <= sda;
        hi_cnt <= scl ? hi_cnt + 1 : 0;
        cyc_cnt <= cyc_cnt + 1;
        if (scl & ~scl_q) rx <= {rx[7:0], sda};
        if (sda_q & ~sda) scl_at_fall <= scl;
        if (scl_q & ~scl & stretch) chk(hi_cnt >= 2 * int'(HALF_CYC), 1'b1);
        if (cyc_cnt == 20000) begin
            num_errors++;
            results();
        end
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            num_errors++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic chk(input logic s, input logic e);
        check({31'h0, s}, {31'h0, e});
    endtask
    task automatic results();
        $display("comparisons %0d errors %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    // ------------------------------------------------------------
    // wishbone classic cycle and scenarios
    // ------------------------------------------------------------
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; dat <= d;
        @(posedge clk_i);
        while (ack !== 1'b1) @(posedge clk_i);
        rd = dat_o;
        cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
        @(posedge clk_i);
    endtask
    task automatic wait_irq();
        rd = 32'h0;
        while (rd[ST_PIRQ] !== 1'b1) wb(1'b0, ADR_STATUS, 32'h0);
    endtask
    task automatic t_regs();
        wb(1'b0, ADR_RELOAD, 32'h0); check(rd, 32'h0000_0009);
        wb(1'b1, ADR_RELOAD, 32'h0000_0083);
        wb(1'b0, ADR_RELOAD, 32'h0); check(rd, 32'h0000_0003);
        wb(1'b0, 8'h10, 32'h0); check(rd, 32'h0000_0000);
    endtask
    task automatic t_cond(input logic [31:0] req, input int bitn);
        wb(1'b1, ADR_CTRL2, req);
        wb(1'b1, ADR_CTRL2, 32'h0000_0002 ^ req);
        wb(1'b1, ADR_BUFFER, 32'h0000_005A);
        wb(1'b0, ADR_STATUS, 32'h0); chk(rd[ST_WRITE_COLLISION_FLAG], 1'b1); chk(rd[ST_BF], 1'b0);
        wait_irq(); chk(rd[ST_SDET], 1'b1); chk(rd[ST_WRITE_COLLISION_FLAG], 1'b1);
        chk(scl_at_fall, 1'b1); chk(drv.sda_oe, 1'b1);
        wb(1'b0, ADR_CTRL2, 32'h0); check({30'h0, rd[1:0]}, 32'h0);
        wb(1'b1, ADR_STATUS, 32'h0000_0086);
    endtask
    task automatic t_byte(input logic [7:0] b, input logic a);
        ack_en <= a; stretch <= 1'b1;
        wb(1'b1, ADR_BUFFER, {24'h0, b});
        wb(1'b0, ADR_STATUS, 32'h0); chk(rd[ST_BF], 1'b1);
        wb(1'b1, ADR_BUFFER, 32'h0000_00FF);
        wb(1'b0, ADR_STATUS, 32'h0); chk(rd[ST_WRITE_COLLISION_FLAG], 1'b1);
        wait_irq(); chk(rd[ST_BF], 1'b0);
        check({23'h0, rx}, {23'h0, b, ~a});
        wb(1'b0, ADR_CTRL2, 32'h0); chk(rd[C2_ACKRCV], ~a);
        chk(drv.scl_oe, 1'b1); chk(drv.sda_oe, 1'b0);
        wb(1'b1, ADR_STATUS, 32'h0000_0086); stretch <= 1'b0;
    endtask
    task automatic t_sleep();
        ack_en <= 1'b1; slp <= 1'b1;
        wb(1'b1, ADR_BUFFER, 32'h0000_0081);
        repeat (600) @(posedge clk_i);
        wb(1'b0, ADR_STATUS, 32'h0); chk(rd[ST_PIRQ], 1'b0); chk(rd[ST_BF], 1'b1);
        chk(scl, 1'b0);
        slp <= 1'b0;
        wait_irq(); chk(rd[ST_BF], 1'b0);
        wb(1'b1, ADR_CTRL2, 32'h0000_0001);
        wb(1'b0, ADR_STATUS, 32'h0); chk(rd[ST_CIRQ], 1'b1);
        wb(1'b0, ADR_CTRL2, 32'h0); chk(rd[C2_START], 1'b0);
    endtask
    initial begin
        {cyc, stb, we, adr, dat, ack_en, stretch, slp} = '0;
        rst_i = 1'b1;
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        t_regs();
        t_cond(32'h0000_0001, C2_START);
        t_byte(8'hA5, 1'b1);
        t_cond(32'h0000_0002, C2_RESTRT);
        t_byte(8'h3C, 1'b0);
        t_sleep();
        results();
    end
endmodule // i2cms_top_tb
